// ### hdl/ais_input_config.sv
`timescale 1ns/1ps
`default_nettype none

module ais_input_config (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Register port
  input wire ais_pkg::ais_bus_req_type bus_in,
  output logic [15:0] rdata_out,
  // Converter core sequencing
  input wire logic seq_restart_in,
  input wire logic sample_done_in,
  // Input selection to the sample/hold
  output logic [3:0] pos_channel_out,
  output logic neg_is_an1_out,
  output logic mux_b_active_out,
  // Pin and reference configuration
  output logic [12:0] pin_digital_out,
  output logic bandgap_enable_out,
  // Conversion clock
  output logic conv_clk_en_out
);

  logic [15:0] input_select_q;
  logic [15:0] pin_config_q;
  logic [15:0] scan_select_q;
  logic [15:0] conv_control_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [15:0] scan_mask;
  logic [3:0] scan_idx_q;
  logic scan_active;
  logic alt_mode;
  ais_pkg::ais_mux_type mux_q;
  logic [3:0] pos_channel_q;
  logic neg_is_an1_q;
  logic [7:0] period_len;
  logic [7:0] period_cnt_q;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // First selected channel strictly after cur, ascending with wrap.
  function automatic logic [3:0] next_scan(input logic [3:0] cur, input logic [15:0] mask);
    logic [3:0] idx;
    logic [3:0] found;
    logic hit;
    found = cur;
    hit = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      idx = cur + i[3:0];
      if (!hit && mask[idx]) begin
        found = idx;
        hit = 1'b1;
      end
    end
    return found;
  endfunction : next_scan

  // Oscillator periods per conversion clock; reserved dividers saturate.
  function automatic logic [7:0] conv_len(input logic [7:0] div);
    logic [7:0] d;
    d = (div > ais_pkg::DIV_MAX_VALID) ? ais_pkg::DIV_MAX_VALID : div;
    return 8'((d + 8'h01) * 8'(ais_pkg::OSC_PER_CYCLE));
  endfunction : conv_len

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      input_select_q <= ais_pkg::RESET_REG;
      pin_config_q <= ais_pkg::RESET_REG;
      scan_select_q <= ais_pkg::RESET_REG;
      conv_control_q <= ais_pkg::RESET_REG;
    end else if (bus_in.wr) begin
      case (bus_in.addr)
        ais_pkg::ADDR_INPUT_SELECT: input_select_q <= bus_in.wdata & ais_pkg::MASK_INPUT_SELECT;
        ais_pkg::ADDR_PIN_ANALOG_CONFIG: pin_config_q <= bus_in.wdata & ais_pkg::MASK_PIN_CONFIG;
        ais_pkg::ADDR_SCAN_SELECT: scan_select_q <= bus_in.wdata & ais_pkg::MASK_SCAN_SELECT;
        ais_pkg::ADDR_CONV_CONTROL: conv_control_q <= bus_in.wdata & ais_pkg::MASK_CONV_CONTROL;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    case (bus_in.addr)
      ais_pkg::ADDR_INPUT_SELECT: rdata_d = input_select_q;
      ais_pkg::ADDR_PIN_ANALOG_CONFIG: rdata_d = pin_config_q;
      ais_pkg::ADDR_SCAN_SELECT: rdata_d = scan_select_q;
      ais_pkg::ADDR_CONV_CONTROL: rdata_d = conv_control_q;
      ais_pkg::ADDR_STATUS: rdata_d = {10'h000, neg_is_an1_q, mux_q == ais_pkg::MUX_B, pos_channel_q};
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rdata_q <= 16'h0000;
    end else if (bus_in.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign rdata_out = rdata_q;

  // ----------------------------------------------------------------
  // Pin and reference configuration
  // ----------------------------------------------------------------
  assign pin_digital_out = pin_config_q[12:0];
  assign bandgap_enable_out = ~pin_config_q[ais_pkg::BANDGAP_BIT];

  // ----------------------------------------------------------------
  // Scan sequencing and multiplexer alternation
  // ----------------------------------------------------------------
  assign scan_mask = {scan_select_q[ais_pkg::BANDGAP_BIT], 2'b00, scan_select_q[12:0]};
  assign scan_active = conv_control_q[ais_pkg::SCAN_ENABLE_BIT] && (scan_mask != 16'h0000);
  assign alt_mode = conv_control_q[ais_pkg::ALT_MODE_BIT];

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      mux_q <= ais_pkg::MUX_A;
    end else if (seq_restart_in || !alt_mode) begin
      mux_q <= ais_pkg::MUX_A;
    end else if (sample_done_in) begin
      mux_q <= (mux_q == ais_pkg::MUX_A) ? ais_pkg::MUX_B : ais_pkg::MUX_A;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      scan_idx_q <= 4'h0;
    end else if (seq_restart_in || !scan_active) begin
      scan_idx_q <= next_scan(4'hF, scan_mask);
    end else if (!scan_mask[scan_idx_q]) begin
      scan_idx_q <= next_scan(scan_idx_q, scan_mask);
    end else if (sample_done_in && mux_q == ais_pkg::MUX_A) begin
      scan_idx_q <= next_scan(scan_idx_q, scan_mask);
    end
  end

  // ----------------------------------------------------------------
  // Registered channel selection to the sample/hold
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pos_channel_q <= 4'h0;
      neg_is_an1_q <= 1'b0;
    end else if (mux_q == ais_pkg::MUX_B) begin
      pos_channel_q <= input_select_q[ais_pkg::POS_SEL_B_LSB +: 4];
      neg_is_an1_q <= input_select_q[ais_pkg::NEG_SEL_B_BIT];
    end else begin
      pos_channel_q <= scan_active ? scan_idx_q : input_select_q[ais_pkg::POS_SEL_A_LSB +: 4];
      neg_is_an1_q <= input_select_q[ais_pkg::NEG_SEL_A_BIT];
    end
  end

  assign pos_channel_out = pos_channel_q;
  assign neg_is_an1_out = neg_is_an1_q;
  assign mux_b_active_out = (mux_q == ais_pkg::MUX_B);

  // ----------------------------------------------------------------
  // Conversion clock enable
  // ----------------------------------------------------------------
  assign period_len = conv_len(conv_control_q[7:0]);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      period_cnt_q <= 8'h00;
    end else if (period_cnt_q >= period_len - 8'h01) begin
      period_cnt_q <= 8'h00;
    end else begin
      period_cnt_q <= period_cnt_q + 8'h01;
    end
  end

  assign conv_clk_en_out = (period_cnt_q >= period_len - 8'h01);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [7:0] gap_q;
  logic seen_q;
  logic [7:0] len_prev_q;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      gap_q <= 8'h01;
      seen_q <= 1'b0;
      len_prev_q <= 8'h02;
    end else begin
      gap_q <= conv_clk_en_out ? 8'h01 : gap_q + 8'h01;
      seen_q <= seen_q | conv_clk_en_out;
      len_prev_q <= period_len;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_neg_b;
    mux_q == ais_pkg::MUX_B |=> neg_is_an1_out == $past(input_select_q[15]);
  endproperty
  a_neg_b: assert property (p_neg_b) else $error("set B negative input wrong");

  property p_neg_a;
    mux_q == ais_pkg::MUX_A |=> neg_is_an1_out == $past(input_select_q[7]);
  endproperty
  a_neg_a: assert property (p_neg_a) else $error("set A negative input wrong");

  property p_pos_b;
    mux_q == ais_pkg::MUX_B |=> pos_channel_out == $past(input_select_q[11:8]);
  endproperty
  a_pos_b: assert property (p_pos_b) else $error("set B positive input wrong");

  property p_pos_a;
    mux_q == ais_pkg::MUX_A && !scan_active |=> pos_channel_out == $past(input_select_q[3:0]);
  endproperty
  a_pos_a: assert property (p_pos_a) else $error("set A positive input wrong");

  property p_scan_src;
    mux_q == ais_pkg::MUX_A && scan_active |=> scan_mask[pos_channel_out] || $changed(scan_mask);
  endproperty
  a_scan_src: assert property (p_scan_src) else $error("scan picked unselected channel");

  property p_bandgap;
    bus_in.wr && bus_in.addr == ais_pkg::ADDR_PIN_ANALOG_CONFIG
      |=> bandgap_enable_out == !$past(bus_in.wdata[15]) && pin_digital_out == $past(bus_in.wdata[12:0]);
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("pin config not applied");

  property p_reserved;
    bus_in.rd && bus_in.addr == ais_pkg::ADDR_INPUT_SELECT |=> rdata_out[14:12] == 3'h0 && rdata_out[6:4] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

  property p_reset_zero;
    $rose(rst_b_in) |-> input_select_q == 16'h0000 && pin_config_q == 16'h0000 && scan_select_q == 16'h0000;
  endproperty
  a_reset_zero: assert property (@(posedge clk_in) p_reset_zero) else $error("registers not zero after reset");

  property p_alt_toggle;
    alt_mode && sample_done_in && !seq_restart_in ##1 alt_mode |-> mux_q != $past(mux_q);
  endproperty
  a_alt_toggle: assert property (p_alt_toggle) else $error("alternate mode did not toggle");

  property p_alt_off;
    !alt_mode |=> mux_q == ais_pkg::MUX_A;
  endproperty
  a_alt_off: assert property (p_alt_off) else $error("set B used without alternate mode");

  property p_period_gap;
    conv_clk_en_out && seen_q && period_len == len_prev_q && $stable(period_len) |-> gap_q == period_len;
  endproperty
  a_period_gap: assert property (p_period_gap) else $error("conversion clock period wrong");

  property p_period_max;
    period_len <= 8'h80 && period_len >= 8'h02;
  endproperty
  a_period_max: assert property (p_period_max) else $error("conversion period out of range");

  property p_scan_step;
    scan_active && sample_done_in && mux_q == ais_pkg::MUX_A && !seq_restart_in && scan_mask[scan_idx_q]
      && $stable(scan_mask) ##1 $stable(scan_mask) |-> scan_idx_q == next_scan($past(scan_idx_q), scan_mask);
  endproperty
  a_scan_step: assert property (p_scan_step) else $error("scan did not step ascending");

  c_scan_wrap: cover property (scan_active && sample_done_in ##1 scan_idx_q < $past(scan_idx_q));
  c_mux_b: cover property (mux_q == ais_pkg::MUX_B ##1 mux_q == ais_pkg::MUX_A);
  c_bandgap_scan: cover property (scan_active && pos_channel_out == ais_pkg::BANDGAP_CHANNEL);
  c_slow_period: cover property (conv_clk_en_out && period_len == 8'h80);

endmodule : ais_input_config

`default_nettype wire

// ### hdl/ais_pkg.sv
package ais_pkg;

  // ----------------------------------------------------------------
  // Register map, word indexes on the plain register port
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_INPUT_SELECT = 3'h0;
  localparam logic [2:0] ADDR_PIN_ANALOG_CONFIG = 3'h1;
  localparam logic [2:0] ADDR_SCAN_SELECT = 3'h2;
  localparam logic [2:0] ADDR_CONV_CONTROL = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;

  // ----------------------------------------------------------------
  // Writable bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_INPUT_SELECT = 16'h8F8F;
  localparam logic [15:0] MASK_PIN_CONFIG = 16'h9FFF;
  localparam logic [15:0] MASK_SCAN_SELECT = 16'h9FFF;
  localparam logic [15:0] MASK_CONV_CONTROL = 16'h03FF;
  localparam logic [15:0] RESET_REG = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NEG_SEL_B_BIT = 15;
  localparam int POS_SEL_B_LSB = 8;
  localparam int NEG_SEL_A_BIT = 7;
  localparam int POS_SEL_A_LSB = 0;
  localparam int BANDGAP_BIT = 15;
  localparam int SCAN_ENABLE_BIT = 8;
  localparam int ALT_MODE_BIT = 9;
  localparam int STAT_MUX_B_BIT = 4;
  localparam int STAT_NEG_BIT = 5;

  // ----------------------------------------------------------------
  // Channel codes and clock timing
  // ----------------------------------------------------------------
  localparam logic [3:0] BANDGAP_CHANNEL = 4'hF;
  localparam logic [7:0] DIV_MAX_VALID = 8'h3F;
  localparam int OSC_PER_CYCLE = 2;

  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ais_bus_req_type;

  typedef enum logic [0:0] {
    MUX_A = 1'b0,
    MUX_B = 1'b1
  } ais_mux_type;

endpackage : ais_pkg

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;

  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  logic clk_in;
  logic rst_b_in = 1'b0;
  ais_pkg::ais_bus_req_type bus_in = '0;
  logic seq_restart_in = 1'b0;
  logic sample_done_in = 1'b0;
  logic [15:0] rdata_out;
  logic [3:0] pos_channel_out;
  logic neg_is_an1_out;
  logic mux_b_active_out;
  logic [12:0] pin_digital_out;
  logic bandgap_enable_out;
  logic conv_clk_en_out;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  logic rd_seen = 1'b0;
  logic [15:0] exp_q[$];
  string name_q[$];
  logic [15:0] r;
  logic [15:0] masks [8] = '{ais_pkg::MASK_INPUT_SELECT, ais_pkg::MASK_PIN_CONFIG, ais_pkg::MASK_SCAN_SELECT,
    ais_pkg::MASK_CONV_CONTROL, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [3:0] codes [14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hF};
  logic [7:0] divs [5] = '{8'h00, 8'h01, 8'h3F, 8'h40, 8'hFF};

  ais_input_config DUT (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .seq_restart_in(seq_restart_in), .sample_done_in(sample_done_in), .pos_channel_out(pos_channel_out),
    .neg_is_an1_out(neg_is_an1_out), .mux_b_active_out(mux_b_active_out), .pin_digital_out(pin_digital_out),
    .bandgap_enable_out(bandgap_enable_out), .conv_clk_en_out(conv_clk_en_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // Read data stand only in the cycle after the strobe, so they are taken there.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (rd_seen) begin
      if (exp_q.size() == 0) check("unexpected read", rdata_out, 16'h0000);
      else check(name_q.pop_front(), rdata_out, exp_q.pop_front());
    end
    rd_seen <= bus_in.rd & rst_b_in;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic bus_op(input logic w, input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus_in <= ais_pkg::ais_bus_req_type'{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge clk_in);
    bus_in <= '0;
  endtask : bus_op

  task automatic rd_chk(input string what, input logic [2:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    name_q.push_back(what);
    bus_op(1'b0, a, 16'h0000);
  endtask : rd_chk

  task automatic seq(input logic restart);
    @(posedge clk_in);
    seq_restart_in <= restart;
    sample_done_in <= ~restart;
    @(posedge clk_in);
    seq_restart_in <= 1'b0;
    sample_done_in <= 1'b0;
  endtask : seq

  task automatic expect_sel(input logic [3:0] pos, input logic b, input logic neg);
    rd_chk("status", ais_pkg::ADDR_STATUS, {10'h000, neg, b, pos});
    check("pos_channel_out", {12'h000, pos_channel_out}, {12'h000, pos});
    check("neg_is_an1_out", {15'h0000, neg_is_an1_out}, {15'h0000, neg});
    check("mux_b_active_out", {15'h0000, mux_b_active_out}, {15'h0000, b});
  endtask : expect_sel

  task automatic do_reset();
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
  endtask : do_reset

  task automatic period_chk(input logic [7:0] div);
    int n;
    int e;
    e = 2 * ((div > ais_pkg::DIV_MAX_VALID ? 63 : int'(div)) + 1);
    bus_op(1'b1, ais_pkg::ADDR_CONV_CONTROL, {8'h00, div});
    repeat (3) begin
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (conv_clk_en_out !== 1'b1 && n < 300);
    end
    check("conv clock period", n[15:0], e[15:0]);
  endtask : period_chk

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(68));
    do_reset();
    for (int a = 0; a < 5; a++) rd_chk("reset value", a[2:0], 16'h0000);
    check("bandgap_enable_out", {15'h0000, bandgap_enable_out}, 16'h0001);
    check("pin_digital_out", {3'h0, pin_digital_out}, 16'h0000);
    $display("test reset values done");
    for (int a = 0; a < 8; a++) begin
      for (int k = 0; k < 2 && a != 4; k++) begin
        r = k ? 16'($urandom) : 16'hFFFF;
        if (a == 0 && k) begin
          r[3:0] = codes[r[3:0] % 14];
          r[11:8] = codes[r[11:8] % 14];
        end
        bus_op(1'b1, a[2:0], r);
        rd_chk("register readback", a[2:0], r & masks[a]);
        if (a == 1) begin
          check("pin_digital_out", {3'h0, pin_digital_out}, {3'h0, r[12:0]});
          check("bandgap_enable_out", {15'h0000, bandgap_enable_out}, {15'h0000, ~r[15]});
        end
      end
    end
    do_reset();
    rd_chk("second reset", ais_pkg::ADDR_PIN_ANALOG_CONFIG, 16'h0000);
    $display("test register access done");
    bus_op(1'b1, ais_pkg::ADDR_CONV_CONTROL, 16'h0200);
    for (int i = 0; i < 14; i++) begin
      bus_op(1'b1, ais_pkg::ADDR_INPUT_SELECT, {~i[0], 3'h0, codes[13 - i], i[0], 3'h0, codes[i]});
      seq(1'b1);
      expect_sel(codes[i], 1'b0, i[0]);
      seq(1'b0);
      expect_sel(codes[13 - i], 1'b1, ~i[0]);
      seq(1'b0);
      expect_sel(codes[i], 1'b0, i[0]);
    end
    bus_op(1'b1, ais_pkg::ADDR_CONV_CONTROL, 16'h0000);
    seq(1'b0);
    expect_sel(codes[13], 1'b0, 1'b1);
    $display("test input selection done");
    bus_op(1'b1, ais_pkg::ADDR_SCAN_SELECT, 16'h8024);
    bus_op(1'b1, ais_pkg::ADDR_INPUT_SELECT, 16'h0004);
    bus_op(1'b1, ais_pkg::ADDR_CONV_CONTROL, 16'h0100);
    seq(1'b1);
    expect_sel(4'h2, 1'b0, 1'b0);
    seq(1'b0);
    expect_sel(4'h5, 1'b0, 1'b0);
    seq(1'b0);
    expect_sel(4'hF, 1'b0, 1'b0);
    seq(1'b0);
    expect_sel(4'h2, 1'b0, 1'b0);
    bus_op(1'b1, ais_pkg::ADDR_CONV_CONTROL, 16'h0000);
    seq(1'b1);
    expect_sel(4'h4, 1'b0, 1'b0);
    bus_op(1'b1, ais_pkg::ADDR_PIN_ANALOG_CONFIG, 16'h01C0);
    rd_chk("small package pins", ais_pkg::ADDR_PIN_ANALOG_CONFIG, 16'h01C0);
    check("pin_digital_out", {3'h0, pin_digital_out}, 16'h01C0);
    $display("test channel scan done");
    for (int k = 0; k < 5; k++) period_chk(divs[k]);
    $display("test conversion clock done");
    repeat (3) @(posedge clk_in);
    final_report();
  end

endmodule : tb_top

`default_nettype wire
